// file: rtl/bcd_arith_block_compare.sv
// Top of the controller's BCD arithmetic and range table compare block.
// Driven by the program scan sequencer on the same clock; one operation at a time.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - range compare uses low digit N of base word, evaluating N+1 ranges
// - each range is two words after base: lower then upper limit
// - lower below upper: bit set when value inside limits, ends included
// - lower above upper: bit set when value lies outside that range
// - range k drives result bit k, first range bit 0, last bit N
// - every evaluation re-reads base and limits, so updates take effect
// - fault when table word missing, non-BCD or past memory boundary
// - carry clear forces carry flag to zero only when condition is true
// - adder changes nothing when its condition is false
// - adder stores BCD sum of operands plus carry; carry when above 9999
// - adder raises fault if either operand has a non-BCD digit
// - adder and subtractor set zero flag exactly when stored result is zero
// - subtractor takes second operand and carry from first, stores result
// - subtractor forms 10000 plus difference, drops fifth digit
// - subtractor sets carry exactly when first below second plus carry
// - subtractor raises fault if either operand has a non-BCD digit
module bcd_arith_block_compare (
	input  wire logic                          CLK,
	input  wire logic                          RSTN,
	input  wire logic                          OP_START,
	input  wire bcd_pkg::op_t                  OP_CODE,
	input  wire logic                          EXEC_COND,
	input  wire logic [bcd_pkg::WORD_W-1:0]    OPERAND_A,
	input  wire logic [bcd_pkg::WORD_W-1:0]    OPERAND_B,
	input  wire logic [bcd_pkg::DM_AW-1:0]     TABLE_BASE,
	input  wire logic                          DM_WR_EN,
	input  wire logic [bcd_pkg::DM_AW-1:0]     DM_WR_ADDR,
	input  wire logic [bcd_pkg::WORD_W-1:0]    DM_WR_DATA,
	output logic                               BUSY,
	output logic                               DONE,
	output logic [bcd_pkg::WORD_W-1:0]         RESULT,
	output logic                               RESULT_WE,
	output logic                               CARRY_FLAG,
	output logic                               FAULT_FLAG,
	output logic                               ZERO_RESULT_FLAG
);
	import bcd_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		seq_state_t        st;
		logic [TAB_AW-1:0] addr;
		logic [3:0]        count;
		logic [3:0]        idx;
		logic [WORD_W-1:0] value;
		logic [WORD_W-1:0] lower;
		logic [WORD_W-1:0] bits;
		logic [WORD_W-1:0] result;
		logic              result_we;
		logic              done;
		logic              carry;
		logic              fault;
		logic              zero;
	} ctl_state_t;

	ctl_state_t q;
	ctl_state_t d;

	bcd_calc_if calc ();
	dm_port_if  dm ();

	logic [TAB_AW-1:0] next_addr;
	logic [WORD_W-1:0] upper;
	logic              in_band;
	logic              out_band;
	logic              hit;

	// ----------------------------------------------------------------
	// sub-blocks
	// ----------------------------------------------------------------
	bcd_addsub u_addsub (
		.io (calc.calc)
	);

	range_table_mem u_mem (
		.CLK  (CLK),
		.RSTN (RSTN),
		.io   (dm.mem)
	);

	assign calc.a   = OPERAND_A;
	assign calc.b   = OPERAND_B;
	assign calc.cin = q.carry;
	assign calc.sub = (OP_CODE == OP_SUB);

	assign dm.wr_en   = DM_WR_EN;
	assign dm.wr_addr = DM_WR_ADDR;
	assign dm.wr_data = DM_WR_DATA;
	// table words are fetched afresh on every compare, never cached
	assign dm.rd_addr = d.addr[DM_AW-1:0];

	// ----------------------------------------------------------------
	// range test on the word that just arrived as upper limit
	// ----------------------------------------------------------------
	// packed BCD orders like binary, so plain compares are enough
	assign upper    = dm.rd_data;
	assign in_band  = (q.value >= q.lower) && (q.value <= upper);
	assign out_band = (q.value < upper) || (q.value > q.lower);
	assign hit      = (q.lower > upper) ? out_band : in_band;
	assign next_addr = TAB_AW'(q.addr + 6'h01);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d           = q;
		d.done      = 1'b0;
		d.result_we = 1'b0;
		case (q.st)
			S_IDLE: begin
				if (OP_START) begin
					d.done = 1'b1;
					if (EXEC_COND) begin
						case (OP_CODE)
							OP_CLC: begin
								d.carry = 1'b0;
							end
							OP_ADD, OP_SUB: begin
								d.fault = calc.bad;
								if (!calc.bad) begin
									d.result    = calc.res;
									d.result_we = 1'b1;
									d.carry     = calc.cout;
									d.zero      = (calc.res == WORD_RST);
								end
							end
							OP_RANGE: begin
								d.fault = 1'b0;
								d.value = OPERAND_A;
								d.bits  = WORD_RST;
								if (TABLE_BASE > BASE_MAX || !is_bcd(OPERAND_A)) begin
									d.fault = 1'b1;
								end else begin
									d.done = 1'b0;
									d.addr = {1'b0, TABLE_BASE};
									d.st   = S_BASE;
								end
							end
							default: begin
								d.done = 1'b1;
							end
						endcase
					end
					// condition false: nothing but the done pulse
				end
			end
			S_BASE: begin
				d.count = dm.rd_data[3:0];
				d.idx   = 4'h0;
				d.addr  = next_addr;
				if (!is_bcd(dm.rd_data) || next_addr >= DM_LIMIT) begin
					d.fault = 1'b1;
					d.done  = 1'b1;
					d.st    = S_IDLE;
				end else begin
					d.st = S_LOW;
				end
			end
			S_LOW: begin
				d.lower = dm.rd_data;
				d.addr  = next_addr;
				if (!is_bcd(dm.rd_data) || next_addr >= DM_LIMIT) begin
					d.fault = 1'b1;
					d.done  = 1'b1;
					d.st    = S_IDLE;
				end else begin
					d.st = S_HIGH;
				end
			end
			S_HIGH: begin
				d.bits[q.idx] = hit;
				if (!is_bcd(dm.rd_data)) begin
					d.fault = 1'b1;
					d.done  = 1'b1;
					d.st    = S_IDLE;
				end else if (q.idx == q.count) begin
					d.result    = d.bits;
					d.result_we = 1'b1;
					d.done      = 1'b1;
					d.st        = S_IDLE;
				end else if (next_addr >= DM_LIMIT) begin
					d.fault = 1'b1;
					d.done  = 1'b1;
					d.st    = S_IDLE;
				end else begin
					d.idx  = 4'(q.idx + 4'h1);
					d.addr = next_addr;
					d.st   = S_LOW;
				end
			end
			default: begin
				d.st = S_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			q        <= '0;
			q.st     <= S_IDLE;
			q.result <= WORD_RST;
			q.carry  <= CARRY_RST;
			q.fault  <= FAULT_RST;
			q.zero   <= ZERO_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign BUSY             = (q.st != S_IDLE);
	assign DONE             = q.done;
	assign RESULT           = q.result;
	assign RESULT_WE        = q.result_we;
	assign CARRY_FLAG       = q.carry;
	assign FAULT_FLAG       = q.fault;
	assign ZERO_RESULT_FLAG = q.zero;

endmodule

`default_nettype wire

// file: rtl/bcd_pkg.sv
// Shared constants, types and helpers for the BCD arithmetic and range compare block.
// Assumes one system clock and a synchronous, active-low reset in every user.

package bcd_pkg;

	// ----------------------------------------------------------------
	// word layout
	// ----------------------------------------------------------------
	localparam int WORD_W  = 16;
	localparam int DIGITS  = 4;
	localparam int DIGIT_W = 4;
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [3:0] DIGIT_RADIX = 4'hA;

	// ----------------------------------------------------------------
	// data memory area
	// ----------------------------------------------------------------
	localparam int DM_WORDS = 32;
	localparam int DM_AW    = 5;
	localparam int TAB_AW   = 6;
	localparam logic [TAB_AW-1:0] DM_LIMIT  = 6'h20;
	localparam logic [DM_AW-1:0]  BASE_MAX  = 5'h0D;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [WORD_W-1:0] WORD_RST  = 16'h0000;
	localparam logic              CARRY_RST = 1'b0;
	localparam logic              FAULT_RST = 1'b0;
	localparam logic              ZERO_RST  = 1'b0;

	// ----------------------------------------------------------------
	// operations and sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_RANGE,
		OP_CLC,
		OP_ADD,
		OP_SUB
	} op_t;

	typedef enum logic [1:0] {
		S_IDLE,
		S_BASE,
		S_LOW,
		S_HIGH
	} seq_state_t;

	function automatic logic is_bcd(input logic [WORD_W-1:0] w);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < DIGITS; i++) begin
			if (w[i*DIGIT_W +: DIGIT_W] > DIGIT_MAX) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

endpackage

// file: rtl/bcd_links.sv
// Interfaces joining the control module to its adder and its data memory.
// Assumes all three modules sit on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface bcd_calc_if;
	import bcd_pkg::*;
	logic [WORD_W-1:0] a;
	logic [WORD_W-1:0] b;
	logic              cin;
	logic              sub;
	logic [WORD_W-1:0] res;
	logic              cout;
	logic              bad;
	modport calc (input a, b, cin, sub, output res, cout, bad);
	modport user (output a, b, cin, sub, input res, cout, bad);
endinterface

interface dm_port_if;
	import bcd_pkg::*;
	logic              wr_en;
	logic [DM_AW-1:0]  wr_addr;
	logic [WORD_W-1:0] wr_data;
	logic [DM_AW-1:0]  rd_addr;
	logic [WORD_W-1:0] rd_data;
	modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
	modport user (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
endinterface

`default_nettype wire

// file: rtl/bcd_addsub.sv
// Four-digit packed BCD adder / subtractor with carry (borrow) in and out.
// Purely combinational; the caller registers everything it keeps.
`timescale 1ns/1ps
`default_nettype none

module bcd_addsub (
	bcd_calc_if.calc io
);
	import bcd_pkg::*;

	logic [DIGITS:0]   chain;
	logic [DIGITS-1:0] digit_bad;

	assign chain[0] = io.cin;

	// ----------------------------------------------------------------
	// one ripple stage per digit
	// ----------------------------------------------------------------
	for (genvar g = 0; g < DIGITS; g++) begin : g_digit
		logic [3:0] da;
		logic [3:0] db;
		logic [4:0] sum_raw;
		logic [4:0] dif_raw;
		logic       sum_ov;
		logic       dif_neg;
		logic [3:0] sum_fix;
		logic [3:0] dif_fix;
		assign da      = io.a[g*DIGIT_W +: DIGIT_W];
		assign db      = io.b[g*DIGIT_W +: DIGIT_W];
		assign sum_raw = {1'b0, da} + {1'b0, db} + {4'h0, chain[g]};
		assign dif_raw = {1'b0, da} - {1'b0, db} - {4'h0, chain[g]};
		assign sum_ov  = sum_raw > {1'b0, DIGIT_MAX};
		// borrow chain is the same as 10000 + a - b - c with the fifth digit dropped
		assign dif_neg = dif_raw[4];
		assign sum_fix = sum_ov ? 4'(sum_raw - {1'b0, DIGIT_RADIX}) : sum_raw[3:0];
		assign dif_fix = dif_neg ? 4'(dif_raw + {1'b0, DIGIT_RADIX}) : dif_raw[3:0];
		// chain and result stay on continuous drivers only, one slice per stage
		assign io.res[g*DIGIT_W +: DIGIT_W] = io.sub ? dif_fix : sum_fix;
		assign chain[g+1] = io.sub ? dif_neg : sum_ov;
		assign digit_bad[g] = (da > DIGIT_MAX) | (db > DIGIT_MAX);
	end

	assign io.cout = chain[DIGITS];
	assign io.bad  = |digit_bad;

endmodule

`default_nettype wire

// file: rtl/range_table_mem.sv
// Data memory area holding range tables; one write port, one read port.
// Read data come out of a register one clock after the address.
`timescale 1ns/1ps
`default_nettype none

module range_table_mem (
	input  wire logic CLK,
	input  wire logic RSTN,
	dm_port_if.mem    io
);
	import bcd_pkg::*;

	typedef struct packed {
		logic [DM_WORDS-1:0][WORD_W-1:0] words;
		logic [WORD_W-1:0]               rd_data;
	} dm_state_t;

	dm_state_t st_q;
	dm_state_t st_d;

	always_comb begin
		st_d = st_q;
		// read before write: a same-cycle write shows on the next read
		st_d.rd_data = st_q.words[io.rd_addr];
		if (io.wr_en) begin
			st_d.words[io.wr_addr] = io.wr_data;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign io.rd_data = st_q.rd_data;

endmodule

`default_nettype wire

// file: verif/bcd_block_props.sv
// Checker on the top ports of the BCD arithmetic and range compare block.
// Assumes one clock and a synchronous active-low reset; attached by bind.
`timescale 1ns/1ps
`default_nettype none

module bcd_block_props (
	input wire logic			CLK,
	input wire logic			RSTN,
	input wire logic			OP_START,
	input wire bcd_pkg::op_t	OP_CODE,
	input wire logic			EXEC_COND,
	input wire logic [15:0]		OPERAND_A,
	input wire logic [15:0]		OPERAND_B,
	input wire logic [4:0]		TABLE_BASE,
	input wire logic			BUSY,
	input wire logic			DONE,
	input wire logic [15:0]		RESULT,
	input wire logic			RESULT_WE,
	input wire logic			CARRY_FLAG,
	input wire logic			FAULT_FLAG,
	input wire logic			ZERO_RESULT_FLAG
);
	import bcd_pkg::*;
	logic	take;
	logic	arith;
	logic	ok_ab;
	function automatic logic ok(input logic [15:0] w);
		return w[3:0] < 4'hA && w[7:4] < 4'hA && w[11:8] < 4'hA && w[15:12] < 4'hA;
	endfunction
	assign take = OP_START && !BUSY && EXEC_COND;
	assign arith = take && (OP_CODE == OP_ADD || OP_CODE == OP_SUB);
	assign ok_ab = ok(OPERAND_A) && ok(OPERAND_B);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	a_clc_clears_carry:
		assert property (take && OP_CODE == OP_CLC |=> DONE && !CARRY_FLAG) else $error("carry left set");
	a_cond_false_idle:
		assert property (OP_START && !BUSY && !EXEC_COND |=> DONE && !RESULT_WE && $stable(RESULT)
			&& $stable(CARRY_FLAG)) else $error("state moved with condition false");
	a_bad_operand_fault:
		assert property (arith && !ok_ab |=> DONE && FAULT_FLAG && !RESULT_WE) else $error("no fault");
	a_arith_writes:
		assert property (arith && ok_ab |=> RESULT_WE && !FAULT_FLAG) else $error("result not written");
	a_zero_tracks_result:
		assert property (arith && ok_ab |=> ZERO_RESULT_FLAG == (RESULT == 16'h0000)) else $error("zero wrong");
	a_sub_borrow_out:
		assert property (arith && ok_ab && OP_CODE == OP_SUB |=> CARRY_FLAG ==
			($past(OPERAND_A) < {1'b0, $past(OPERAND_B)} + $past(CARRY_FLAG))) else $error("borrow wrong");
	a_base_limit:
		assert property (take && OP_CODE == OP_RANGE && TABLE_BASE > BASE_MAX |=> DONE && FAULT_FLAG
			&& !RESULT_WE) else $error("base above limit accepted");
	a_range_starts:
		assert property (take && OP_CODE == OP_RANGE && TABLE_BASE <= BASE_MAX && ok(OPERAND_A) |=> BUSY)
			else $error("range compare not started");
	a_busy_bounded:
		assert property ($rose(BUSY) |-> ##[1:21] !BUSY) else $error("compare runs too long");
endmodule

bind bcd_arith_block_compare bcd_block_props i_props (.CLK, .RSTN, .OP_START, .OP_CODE, .EXEC_COND,
	.OPERAND_A, .OPERAND_B, .TABLE_BASE, .BUSY, .DONE, .RESULT, .RESULT_WE, .CARRY_FLAG, .FAULT_FLAG,
	.ZERO_RESULT_FLAG);

`default_nettype wire

// file: verif/scan_seq.sv
// Model of the program scan sequencer: one request at a time, plus data memory writes.
// Assumes one clock; everything leaves on a rising edge.
`timescale 1ns/1ps
`default_nettype none

module scan_seq (
	input wire logic			clk,
	input wire logic			done,
	output var logic			op_start,
	output var bcd_pkg::op_t	op_code,
	output var logic			exec_cond,
	output var logic [15:0]		opnd_a,
	output var logic [15:0]		opnd_b,
	output var logic [4:0]		base,
	output var logic			wr_en,
	output var logic [4:0]		wr_addr,
	output var logic [15:0]		wr_data
);
	import bcd_pkg::*;
	int	stalls = 0;
	initial begin
		op_start = 1'b0;
		op_code = OP_CLC;
		exec_cond = 1'b0;
		opnd_a = 16'h0000;
		opnd_b = 16'h0000;
		base = 5'h00;
		wr_en = 1'b0;
		wr_addr = 5'h00;
		wr_data = 16'h0000;
	end
	task automatic issue(input op_t op, input logic c, input logic [15:0] a, b, input logic [4:0] bs);
		int n;
		n = 0;
		@(posedge clk);
		op_start <= 1'b1;
		op_code <= op;
		exec_cond <= c;
		opnd_a <= a;
		opnd_b <= b;
		base <= bs;
		@(posedge clk);
		// operands are stale now: show their inverse, not a kind copy
		op_start <= 1'b0;
		exec_cond <= ~c;
		opnd_a <= ~a;
		opnd_b <= ~b;
		base <= ~bs;
		@(negedge clk);
		while (!done && n < 30) begin
			n++;
			@(negedge clk);
		end
		// a request left unanswered counts against the run at the verdict
		if (!done) begin
			stalls++;
		end
	endtask
	task automatic write_word(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		wr_addr <= ~a;
		wr_data <= ~d;
	endtask
endmodule

`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the BCD arithmetic and range compare block.
// Assumes the sequencer model scan_seq and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp=%h got=%h", n, e, g); end end

module testbench;
	import bcd_pkg::*;
	logic	clk, rstn, op_start, exec_cond, wr_en, busy, done, res_we, carry, fault, zero, cy;
	op_t	op_code;
	logic [15:0]	opnd_a, opnd_b, wr_data, res;
	logic [15:0]	shadow [32];
	logic [4:0]	base, wr_addr;
	int	seed = 68;
	int	n_mismatch = 0;
	int	checks_done = 0;
	bcd_arith_block_compare i_dut (.CLK(clk), .RSTN(rstn), .OP_START(op_start), .OP_CODE(op_code),
		.EXEC_COND(exec_cond), .OPERAND_A(opnd_a), .OPERAND_B(opnd_b), .TABLE_BASE(base), .DM_WR_EN(wr_en),
		.DM_WR_ADDR(wr_addr), .DM_WR_DATA(wr_data), .BUSY(busy), .DONE(done), .RESULT(res),
		.RESULT_WE(res_we), .CARRY_FLAG(carry), .FAULT_FLAG(fault), .ZERO_RESULT_FLAG(zero));
	scan_seq i_seq (.clk, .done, .op_start, .op_code, .exec_cond, .opnd_a, .opnd_b, .base, .wr_en,
		.wr_addr, .wr_data);
	function automatic int b2i(input logic [15:0] w);
		return w[15:12] * 1000 + w[11:8] * 100 + w[7:4] * 10 + w[3:0];
	endfunction
	function automatic logic [15:0] i2b(input int v);
		return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
	endfunction
	function automatic logic [15:0] rnd_bcd();
		return i2b($unsigned($random(seed)) % 10000);
	endfunction
	function automatic logic [15:0] range_exp(input logic [15:0] v, input logic [4:0] bs);
		logic [15:0] r;
		logic [15:0] lo;
		logic [15:0] hi;
		r = 16'h0000;
		for (int k = 0; k <= shadow[bs][3:0]; k++) begin
			lo = shadow[bs + 1 + 2 * k];
			hi = shadow[bs + 2 + 2 * k];
			r[k] = (lo <= hi) ? (v >= lo && v <= hi) : (v < hi || v > lo);
		end
		return r;
	endfunction
	task automatic arith(input op_t op, input logic [15:0] a, b);
		int s;
		s = (op == OP_ADD) ? b2i(a) + b2i(b) + cy : 10000 + b2i(a) - b2i(b) - cy;
		i_seq.issue(op, 1'b1, a, b, 5'h00);
		`CHK("result", i2b(s % 10000), res)
		`CHK("carry", (op == OP_ADD) ? s > 9999 : s < 10000, carry)
		`CHK("zero", s % 10000 == 0, zero)
		cy = (op == OP_ADD) ? s > 9999 : s < 10000;
	endtask
	task automatic clc();
		i_seq.issue(OP_CLC, 1'b1, rnd_bcd(), rnd_bcd(), 5'h00);
		`CHK("carry", 1'b0, carry)
		cy = 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		shadow[a] = d;
		i_seq.write_word(a, d);
	endtask
	task automatic rng(input logic [15:0] v, input logic [4:0] bs);
		i_seq.issue(OP_RANGE, 1'b1, v, rnd_bcd(), bs);
		`CHK("range", range_exp(v, bs), res)
		`CHK("fault", 1'b0, fault)
	endtask
	task automatic rng_bad(input logic [4:0] bs);
		i_seq.issue(OP_RANGE, 1'b1, 16'h0100, 16'h0000, bs);
		`CHK("fault", 1'b1, fault)
	endtask
	task automatic tally_and_finish();
		n_mismatch += i_seq.stalls;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		tally_and_finish();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		cy = 1'b0;
		for (int i = 0; i < 32; i++) shadow[i] = 16'h0000;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		arith(OP_ADD, 16'h9999, 16'h0001);
		arith(OP_SUB, 16'h0089, 16'h0100);
		arith(OP_SUB, 16'h0000, 16'h9999);
		for (int i = 0; i < 40; i++) begin
			if (i % 5 == 0) clc();
			arith(($random(seed) & 1) ? OP_ADD : OP_SUB, rnd_bcd(), rnd_bcd());
		end
		$display("test arith done");
		clc();
		arith(OP_ADD, 16'h9999, 16'h9999);
		for (int i = 0; i < 4; i++) begin
			i_seq.issue(op_t'(i), 1'b0, rnd_bcd(), rnd_bcd(), 5'h00);
			`CHK("carry", 1'b1, carry)
			`CHK("result", 16'h9998, res)
		end
		for (int i = 2; i < 4; i++) begin
			i_seq.issue(op_t'(i), 1'b1, i == 2 ? 16'h0A00 : 16'h0001, i == 2 ? 16'h0001 : 16'h000F, 5'h00);
			`CHK("fault", 1'b1, fault)
			`CHK("result", 16'h9998, res)
		end
		$display("test condition and fault done");
		wr(5'd0, 16'h0005);
		for (int i = 0; i < 6; i++) begin
			wr(5'(2 * i + 1), i2b(i == 0 ? 0 : 100 * i + 1));
			wr(5'(2 * i + 2), i2b(100 * (i + 1)));
		end
		rng(16'h0210, 5'd0);
		`CHK("range", 16'h0004, res)
		wr(5'd0, 16'h0001);
		wr(5'd1, 16'h0500);
		wr(5'd2, 16'h0300);
		wr(5'd3, 16'h0210);
		wr(5'd4, 16'h0210);
		rng(16'h0210, 5'd0);
		`CHK("range", 16'h0003, res)
		for (int t = 0; t < 6; t++) begin
			for (int a = 14; a < 32; a++) wr(5'(a), rnd_bcd());
			wr(5'd13, (rnd_bcd() & 16'hFFF0) | 16'(t + 3));
			for (int j = 0; j < 8; j++) rng(($random(seed) & 1) ? shadow[14 + j] : rnd_bcd(), 5'd13);
		end
		rng_bad(5'd14);
		wr(5'd13, 16'h0009);
		rng_bad(5'd13);
		wr(5'd13, 16'h0008);
		wr(5'd20, 16'h00F0);
		rng_bad(5'd13);
		$display("test range done");
		tally_and_finish();
	end
endmodule

`default_nettype wire
